// file: core/aoc_top.sv
// alarm and output conditioning with AXI4-Lite setting registers
`timescale 1ns/1ps
`default_nettype none
`include "aoc_cfg.svh"
module aoc_top import aoc_pkg::*; #(
  parameter int unsigned TICK_CYC = `AOC_SEC_NS / `AOC_CLK_NS,
  parameter int          NALM     = 4,
  parameter int          AVG_D    = 32
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // axi4-lite slave
  input  wire logic [5:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [5:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // process value
  input  wire logic signed [15:0] pv_in,
  input  wire logic              pv_valid,
  output logic signed [15:0]     pv_out,
  output logic                   pv_out_valid,
  // alarms
  input  wire logic [NALM-1:0]   raw_alarm,
  input  wire logic              fkey_cancel,
  input  wire logic              event_cancel,
  output logic [NALM-1:0]        alarm_out,
  output logic [NALM-1:0]        aux_out,
  output logic [NALM-1:0]        aux_ind,
  input  wire logic              hs_raw,
  output logic                   hs_alarm,
  // operator and display
  input  wire aoc_level_t        level,
  input  wire logic              key_active,
  input  wire logic              protect_key,
  output logic                   disp_return,
  output logic                   protect_enter,
  output logic [1:0]             display_brightness_level,
  // control support
  input  wire logic              manual_req,
  input  wire logic              heat_cool,
  input  wire logic signed [15:0] auto_mv,
  output logic signed [15:0]     manual_mv,
  input  wire logic [4:0]        input_type,
  output logic                   cj_internal_on,
  output logic                   id_unit_fine
);

  ////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] sat(input logic [31:0] v, input logic [31:0] lo,
                                      input logic [31:0] hi);
    sat = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : sat

  function automatic logic signed [15:0] clampv(input logic signed [15:0] v,
      input logic signed [15:0] lo, input logic signed [15:0] hi);
    clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clampv

  ////////////////////////////////////////////////////////////////
  // registers
  logic [13:0]       filt_tc_r;
  logic [2:0]        average_count_select_r;
  logic [6:0]        ret_time_r;
  logic [4:0]        protect_entry_hold_time_r;
  aoc_mode_t         mode_r;
  logic signed [15:0] manual_start_value_r;
  logic signed [15:0] mv_lo_r;
  logic signed [15:0] mv_hi_r;
  aoc_alm_cfg_t      acfg_r [NALM];
  logic              aw_hold_r;
  logic              w_hold_r;
  logic [5:0]        awaddr_r;
  logic [31:0]       wdata_r;
  logic              wr_go;
  logic              latch_cancel_function;
  logic              robust_prev_r;
  logic              cfg_lvl;
  logic [NALM-1:0]   latched_r;

  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign wr_go         = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign cfg_lvl       = level inside {LVL_INIT, LVL_COMM, LVL_ADV, LVL_CAL};

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 6'h00;
      wdata_r   <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_r[5:2] <= 4'hB) ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign latch_cancel_function = fkey_cancel || event_cancel ||
                                 (wr_go && awaddr_r == `AOC_A_CMD && wdata_r[0]);

  // setting writes, saturated into their documented ranges, except the mode and MV limit words, which are written as given
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      filt_tc_r                 <= 14'h0000;
      average_count_select_r    <= 3'h0;
      ret_time_r                <= 7'h00;
      display_brightness_level  <= `AOC_BRT_RST;
      protect_entry_hold_time_r <= `AOC_PRT_RST;
      mode_r                    <= '{init_method: 1'b0, limit_en: 1'b0, robust_tune: 1'b0,
                                     cj_internal: 1'b1, hs_en: 1'b1, unit_fine: 1'b0};
      manual_start_value_r      <= 16'sh0000;
      mv_lo_r                   <= `AOC_STD_LO;
      mv_hi_r                   <= `AOC_MV_HI;
      robust_prev_r             <= 1'b0;
      for (int i = 0; i < NALM; i++) acfg_r[i] <= '0;
    end else begin
      robust_prev_r <= mode_r.robust_tune;
      if (wr_go) begin
        if (awaddr_r == `AOC_A_FILT) begin
          filt_tc_r <= 14'(sat(32'(wdata_r[13:0]), 32'd0, `AOC_FILT_MAX));
          average_count_select_r <= 3'(sat(32'(wdata_r[18:16]), 32'd0, `AOC_AVG_MAX));
        end else if (awaddr_r == `AOC_A_DISP) begin
          ret_time_r <= 7'(sat(32'(wdata_r[6:0]), 32'd0, `AOC_RET_MAX));
          display_brightness_level <= 2'(sat(32'(wdata_r[9:8]), `AOC_BRT_MIN,
                                             `AOC_BRT_MAX));
          protect_entry_hold_time_r <= 5'(sat(32'(wdata_r[20:16]), `AOC_PRT_MIN,
                                              `AOC_PRT_MAX));
        end else if (awaddr_r == `AOC_A_MODE) begin
          mode_r <= aoc_mode_t'(wdata_r[5:0]);
        end else if (awaddr_r == `AOC_A_MANV) begin
          manual_start_value_r <= clampv(wdata_r[15:0], heat_cool ? `AOC_HC_LO : `AOC_STD_LO,
                                         `AOC_MV_HI);
        end else if (awaddr_r == `AOC_A_MLIM) begin
          mv_lo_r <= wdata_r[15:0];
          mv_hi_r <= wdata_r[31:16];
        end else if (awaddr_r[5:4] == 2'b10) begin
          acfg_r[awaddr_r[3:2]] <= '{open_in_alarm: wdata_r[25], latch_en: wdata_r[24],
              alm_type: wdata_r[23:20],
              off_dly: 10'(sat(32'(wdata_r[19:10]), 32'd0, `AOC_DLY_MAX)),
              on_dly: 10'(sat(32'(wdata_r[9:0]), 32'd0, `AOC_DLY_MAX))};
        end
      end
      // hardware set of the fine unit wins over a same-cycle write
      if (mode_r.robust_tune && !robust_prev_r) mode_r.unit_fine <= 1'b1;
    end
  end

  // read channel, answer one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      if (s_axi_araddr == `AOC_A_FILT)
        s_axi_rdata <= {13'h0, average_count_select_r, 2'h0, filt_tc_r};
      else if (s_axi_araddr == `AOC_A_DISP)
        s_axi_rdata <= {11'h0, protect_entry_hold_time_r, 6'h0, display_brightness_level,
                        1'b0, ret_time_r};
      else if (s_axi_araddr == `AOC_A_MODE)
        s_axi_rdata <= {26'h0, mode_r};
      else if (s_axi_araddr == `AOC_A_MANV)
        s_axi_rdata <= {manual_mv, manual_start_value_r};
      else if (s_axi_araddr == `AOC_A_MLIM)
        s_axi_rdata <= {mv_hi_r, mv_lo_r};
      else if (s_axi_araddr == `AOC_A_CMD)
        s_axi_rdata <= 32'h0000_0000;
      else if (s_axi_araddr == `AOC_A_STAT)
        s_axi_rdata <= {18'h0, hs_alarm, cj_internal_on, latched_r, aux_out, alarm_out};
      else if (s_axi_araddr == `AOC_A_PV)
        s_axi_rdata <= {16'h0, pv_out};
      else if (s_axi_araddr[5:4] == 2'b10)
        s_axi_rdata <= {6'h0, acfg_r[s_axi_araddr[3:2]]};
      else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'b10;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // seconds timebase
  logic [31:0] tick_cnt_r;
  logic        sec_tick;
  assign sec_tick = (tick_cnt_r == TICK_CYC - 1);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) tick_cnt_r <= 32'h0;
    else tick_cnt_r <= sec_tick ? 32'h0 : tick_cnt_r + 32'h1;
  end

  ////////////////////////////////////////////////////////////////
  // input smoothing: first-order filter then moving average
  logic signed [15:0] filt_r;
  logic signed [16:0] fdiff;
  logic [3:0]         fshift;
  logic               s1_v_r;
  logic signed [15:0] avg_buf [AVG_D];
  logic signed [20:0] avg_sum;
  assign fdiff  = 17'(pv_in) - 17'(filt_r);
  assign fshift = 4'($clog2(32'(filt_tc_r) + 32'd1));
  always_comb begin
    avg_sum = '0;
    for (int i = 0; i < AVG_D; i++)
      if (i < (1 << average_count_select_r)) avg_sum = avg_sum + 21'(avg_buf[i]);
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      filt_r <= 16'sh0000;
      s1_v_r <= 1'b0;
    end else begin
      s1_v_r <= pv_valid;
      if (pv_valid)
        filt_r <= (filt_tc_r == 14'h0) ? pv_in :
                  16'(filt_r + 16'(fdiff >>> fshift));
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < AVG_D; i++) avg_buf[i] <= 16'sh0000;
    end else if (s1_v_r) begin
      avg_buf[0] <= filt_r;
      for (int i = 1; i < AVG_D; i++) avg_buf[i] <= avg_buf[i-1];
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pv_out       <= 16'sh0000;
      pv_out_valid <= 1'b0;
    end else begin
      pv_out_valid <= s1_v_r;
      if (s1_v_r)
        pv_out <= (average_count_select_r == 3'h0) ? filt_r :
                  16'((avg_sum + 21'(filt_r) - 21'(avg_buf[(1 << average_count_select_r) - 1]))
                      >>> average_count_select_r);
    end
  end

  ////////////////////////////////////////////////////////////////
  // alarm delays, latch and auxiliary polarity
  logic [NALM-1:0] dly_out_r;
  logic [9:0]      dcnt_r [NALM];
  logic [NALM-1:0] raw_q_r;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dly_out_r <= '0;
      raw_q_r   <= '0;
      for (int i = 0; i < NALM; i++) dcnt_r[i] <= 10'h0;
    end else begin
      raw_q_r <= raw_alarm;
      for (int i = 0; i < NALM; i++) begin
        if (raw_alarm[i] != raw_q_r[i]) begin
          dcnt_r[i] <= 10'h0;
        end else if (raw_alarm[i] == dly_out_r[i]) begin
          dcnt_r[i] <= 10'h0;
        end else if (acfg_r[i].alm_type == 4'h0 || acfg_r[i].alm_type == `AOC_TYPE_LBA ||
                     acfg_r[i].alm_type == `AOC_TYPE_13) begin
          dly_out_r[i] <= raw_alarm[i];
        end else if (dcnt_r[i] >= (raw_alarm[i] ? acfg_r[i].on_dly : acfg_r[i].off_dly)) begin
          dly_out_r[i] <= raw_alarm[i];
          dcnt_r[i]    <= 10'h0;
        end else if (sec_tick) begin
          dcnt_r[i] <= dcnt_r[i] + 10'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      latched_r <= '0;
    end else begin
      for (int i = 0; i < NALM; i++) begin
        if (dly_out_r[i] && !cfg_lvl && acfg_r[i].latch_en && acfg_r[i].alm_type != 4'h0 &&
            (i == 0 || acfg_r[i].alm_type != `AOC_TYPE_LBA))
          latched_r[i] <= 1'b1;
        else if (latch_cancel_function || cfg_lvl)
          latched_r[i] <= 1'b0;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NALM; i++) begin
      alarm_out[i] = (dly_out_r[i] || latched_r[i]) && !cfg_lvl;
      aux_out[i]   = alarm_out[i] ^ acfg_r[i].open_in_alarm;
      aux_ind[i]   = alarm_out[i];
    end
  end
  assign hs_alarm = hs_raw && mode_r.hs_en;

  ////////////////////////////////////////////////////////////////
  // display return and protect entry
  logic [6:0] idle_r;
  logic [4:0] hold_r;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_r      <= 7'h00;
      disp_return <= 1'b0;
    end else begin
      disp_return <= 1'b0;
      if (key_active || !(level inside {LVL_OPER, LVL_ADJ, LVL_PROG, LVL_PID, LVL_MON})) begin
        idle_r <= 7'h00;
      end else if (ret_time_r != 7'h00 && idle_r >= ret_time_r) begin
        disp_return <= 1'b1;
        idle_r      <= 7'h00;
      end else if (sec_tick && ret_time_r != 7'h00) begin
        idle_r <= idle_r + 7'h1;
      end
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_r        <= 5'h00;
      protect_enter <= 1'b0;
    end else begin
      protect_enter <= 1'b0;
      if (!protect_key) begin
        hold_r <= 5'h00;
      end else if (hold_r >= protect_entry_hold_time_r) begin
        if (hold_r != 5'h1F) protect_enter <= 1'b1;
        hold_r <= 5'h1F;
      end else if (sec_tick) begin
        hold_r <= hold_r + 5'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // manual start value and cold junction
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) manual_mv <= 16'sh0000;
    else if (manual_req)
      manual_mv <= !mode_r.init_method ? auto_mv :
                   (mode_r.limit_en ? clampv(manual_start_value_r, mv_lo_r, mv_hi_r) :
                    manual_start_value_r);
  end
  assign cj_internal_on = mode_r.cj_internal && input_type >= `AOC_CJ_LO &&
                          input_type <= `AOC_CJ_HI;
  assign id_unit_fine   = mode_r.unit_fine;

  ////////////////////////////////////////////////////////////////
  // checks
  sequence s_cancel;
    (fkey_cancel || event_cancel) ##1 1'b1;
  endsequence
  sequence s_robust_rise;
    !mode_r.robust_tune ##1 mode_r.robust_tune;
  endsequence
  AST_NO_FILTER: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pv_valid && filt_tc_r == 14'h0 |=> filt_r == $past(pv_in))
    else $error("filter smoothed with zero time constant");
  AST_AVG_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pv_valid && filt_tc_r == 14'h0 && average_count_select_r == 3'h0
    ##1 average_count_select_r == 3'h0 |=> pv_out == $past(pv_in, 2))
    else $error("pv path not transparent when off");
  AST_LATCH_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    latched_r[2] && !cfg_lvl && !latch_cancel_function |=> latched_r[2])
    else $error("latched alarm dropped without cancel");
  AST_CANCEL: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_cancel and (!dly_out_r[2] ##1 1'b1) |-> !latched_r[2])
    else $error("latch survived cancel");
  AST_CFG_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cfg_lvl |-> alarm_out == '0) else $error("alarm on in setting level");
  AST_AUX_POL: assert property (@(posedge ref_clk) disable iff (sys_rst)
    aux_ind[2] ##0 acfg_r[2].open_in_alarm |-> !aux_out[2])
    else $error("open-in-alarm output not open");
  AST_NO_RETURN: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ret_time_r == 7'h00 [*2] |-> !disp_return) else $error("display returned while off");
  AST_BRIGHT: assert property (@(posedge ref_clk) disable iff (sys_rst)
    display_brightness_level != 2'd0) else $error("brightness out of range");
  AST_ROBUST_UNIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_robust_rise |=> id_unit_fine) else $error("time unit not set on robust tuning");
  AST_MAN_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    manual_req && !mode_r.init_method |=> manual_mv == $past(auto_mv))
    else $error("manual start not from last mv");
  AST_HS_EN: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !mode_r.hs_en |-> !hs_alarm) else $error("hs alarm while disabled");
  AST_ON_DLY: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(dly_out_r[0]) && acfg_r[0].alm_type == 4'h1 |-> $past(dcnt_r[0]) >= acfg_r[0].on_dly)
    else $error("alarm on before on delay");

endmodule : aoc_top
`default_nettype wire

// file: core/aoc_cfg.svh
// constants of the alarm and output conditioning block
`ifndef AOC_CFG_SVH
`define AOC_CFG_SVH
`define AOC_SEC_NS     1000000000
`define AOC_CLK_NS     5
`define AOC_A_FILT     6'h00
`define AOC_A_DISP     6'h04
`define AOC_A_MODE     6'h08
`define AOC_A_MANV     6'h0C
`define AOC_A_MLIM     6'h10
`define AOC_A_CMD      6'h14
`define AOC_A_STAT     6'h18
`define AOC_A_PV       6'h1C
`define AOC_A_ALM0     6'h20
`define AOC_FILT_MAX   32'd9999
`define AOC_AVG_MAX    32'd5
`define AOC_RET_MAX    32'd99
`define AOC_BRT_MIN    32'd1
`define AOC_BRT_MAX    32'd3
`define AOC_PRT_MIN    32'd1
`define AOC_PRT_MAX    32'd30
`define AOC_PRT_RST    5'd3
`define AOC_BRT_RST    2'd3
`define AOC_DLY_MAX    32'd999
`define AOC_STD_LO     16'shFFCE
`define AOC_HC_LO      16'shFBE6
`define AOC_MV_HI      16'sh041A
`define AOC_TYPE_LBA   4'hC
`define AOC_TYPE_13    4'hD
`define AOC_CJ_LO      5'd5
`define AOC_CJ_HI      5'd24
`endif

// file: core/aoc_pkg.sv
// types of the alarm and output conditioning block
package aoc_pkg;
  typedef enum logic [3:0] {
    LVL_OPER, LVL_ADJ, LVL_PROG, LVL_PID, LVL_MON,
    LVL_PROT, LVL_INIT, LVL_COMM, LVL_ADV, LVL_CAL
  } aoc_level_t;
  typedef struct packed {
    logic       open_in_alarm;
    logic       latch_en;
    logic [3:0] alm_type;
    logic [9:0] off_dly;
    logic [9:0] on_dly;
  } aoc_alm_cfg_t;
  typedef struct packed {
    logic        init_method;
    logic        limit_en;
    logic        robust_tune;
    logic        cj_internal;
    logic        hs_en;
    logic        unit_fine;
  } aoc_mode_t;
endpackage : aoc_pkg

// file: dv/alarm_output_conditioning_bench.sv
// self-checking bench of the alarm and output conditioning block
`timescale 1ns/1ps
`default_nettype none
`include "aoc_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module alarm_output_conditioning_bench import aoc_pkg::*;;
  logic                ref_clk = 1'b0, sys_rst = 1'b1;
  logic [5:0]          s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0]         s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [3:0]          s_axi_wstrb = 4'hF;
  logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]          s_axi_bresp, s_axi_rresp, rs, display_brightness_level;
  logic signed [15:0]  pv_in = 16'sh0000, auto_mv = 16'sh0000, pv_out, manual_mv;
  logic                pv_valid = 1'b0, fkey_cancel = 1'b0, event_cancel = 1'b0, hs_raw = 1'b0;
  logic                key_active = 1'b0, protect_key = 1'b0, manual_req = 1'b0, heat_cool = 1'b0;
  logic                pv_out_valid, hs_alarm, disp_return, protect_enter;
  logic                cj_internal_on, id_unit_fine;
  logic [3:0]          raw_alarm = 4'h0, alarm_out, aux_out, aux_ind;
  logic [4:0]          input_type = 5'h05;
  aoc_level_t          level = LVL_OPER;
  int                  fails = 0, total_checks = 0, n_ret = 0, n_prot = 0, k;

  aoc_top #(.TICK_CYC(10)) DUT (.ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pv_in, .pv_valid, .pv_out, .pv_out_valid,
    .raw_alarm, .fkey_cancel, .event_cancel, .alarm_out, .aux_out, .aux_ind, .hs_raw, .hs_alarm,
    .level, .key_active, .protect_key, .disp_return, .protect_enter, .display_brightness_level,
    .manual_req, .heat_cool, .auto_mv, .manual_mv, .input_type, .cj_internal_on, .id_unit_fine);

  initial forever #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (disp_return === 1'b1) n_ret <= n_ret + 1;
    if (protect_enter === 1'b1) n_prot <= n_prot + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic tmo();
    fails++;
    print_verdict();
  endtask : tmo
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 64);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 64) tmo();
  endtask : wr
  task automatic rdr(input logic [5:0] a);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 64);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 64) tmo();
  endtask : rdr
  task automatic pv(input logic signed [15:0] x);
    @(posedge ref_clk);
    pv_in <= x;
    pv_valid <= 1'b1;
    @(posedge ref_clk);
    pv_valid <= 1'b0;
    cyc(2);
    `CHK(pv_out_valid, 1'b1)
    cyc(1);
  endtask : pv
  task automatic mreq();
    @(posedge ref_clk);
    manual_req <= 1'b1;
    @(posedge ref_clk);
    manual_req <= 1'b0;
    cyc(3);
  endtask : mreq
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    hs_raw <= 1'b1;
    cyc(2);
    `CHK(display_brightness_level, 2'h3)
    `CHK(hs_alarm, 1'b1)
    `CHK(cj_internal_on, 1'b1)
    `CHK(alarm_out, 4'h0)
    rdr(`AOC_A_DISP);
    `CHK(rd & 32'h001F_037F, 32'h0003_0300)
    rdr(`AOC_A_MODE);
    `CHK(rd[5:0], 6'h06)
    rdr(`AOC_A_ALM0);
    `CHK(rd[24], 1'b0)
    rdr(6'h30);
    `CHK(rs, 2'h2)
    wr(6'h30, 32'h0000_0001);
    `CHK(rs, 2'h2)
    // smoothing off, then moving averages of two and four
    pv(16'sh0064);
    `CHK(pv_out, 16'sh0064)
    wr(`AOC_A_FILT, 32'h0001_0000);
    pv(16'sh0014);
    pv(16'sh0028);
    pv(16'sh0050);
    `CHK(pv_out, 16'sh003C)
    wr(`AOC_A_FILT, 32'h0002_0000);
    for (int i = 1; i <= 4; i++) pv(16'(8 * i));
    `CHK(pv_out, 16'sh0014)
    wr(`AOC_A_FILT, 32'h0000_0001);
    pv(16'sh0060);
    `CHK(pv_out > 16'sh0020 && pv_out < 16'sh0060, 1'b1)
    // on delay of 2 s on alarm 0, short pulses must not pass
    wr(`AOC_A_ALM0, 32'h0010_0002);
    raw_alarm[0] <= 1'b1;
    cyc(8);
    `CHK(alarm_out[0], 1'b0)
    raw_alarm[0] <= 1'b0;
    cyc(4);
    raw_alarm[0] <= 1'b1;
    cyc(8);
    `CHK(alarm_out[0], 1'b0)
    cyc(30);
    `CHK(alarm_out[0], 1'b1)
    raw_alarm[0] <= 1'b0;
    cyc(4);
    `CHK(alarm_out[0], 1'b0)
    wr(`AOC_A_ALM0 + 6'h04, 32'h0010_0800);
    raw_alarm[1] <= 1'b1;
    cyc(4);
    `CHK(alarm_out[1], 1'b1)
    raw_alarm[1] <= 1'b0;
    cyc(6);
    `CHK(alarm_out[1], 1'b1)
    cyc(30);
    `CHK(alarm_out[1], 1'b0)
    wr(`AOC_A_ALM0 + 6'h0C, 32'h00D0_0005);
    raw_alarm[3] <= 1'b1;
    cyc(3);
    `CHK(alarm_out[3], 1'b1)
    // latched open-in-alarm output, cancelled by key, then by event, then by a command write
    wr(`AOC_A_ALM0 + 6'h08, 32'h0310_0000);
    for (int i = 0; i < 3; i++) begin
      raw_alarm[2] <= 1'b1;
      cyc(4);
      `CHK(aux_ind[2], 1'b1)
      raw_alarm[2] <= 1'b0;
      cyc(6);
      `CHK(alarm_out[2], 1'b1)
      `CHK(aux_out[2], 1'b0)
      rdr(`AOC_A_STAT);
      `CHK(rd[13:0], 14'h348C)
      if (i == 0) fkey_cancel <= 1'b1;
      else if (i == 1) event_cancel <= 1'b1;
      else wr(`AOC_A_CMD, 32'h0000_0001);
      cyc(1);
      fkey_cancel <= 1'b0;
      event_cancel <= 1'b0;
      cyc(3);
      `CHK(alarm_out[2], 1'b0)
      `CHK(aux_out[2], 1'b1)
    end
    raw_alarm[2] <= 1'b1;
    cyc(4);
    raw_alarm[2] <= 1'b0;
    level <= LVL_INIT;
    cyc(3);
    `CHK(alarm_out, 4'h0)
    level <= LVL_OPER;
    raw_alarm[3] <= 1'b0;
    cyc(4);
    `CHK(alarm_out[2], 1'b0)
    // display return, brightness and protect entry
    wr(`AOC_A_DISP, 32'h0003_0100);
    `CHK(display_brightness_level, 2'h1)
    cyc(40);
    `CHK(n_ret, 0)
    wr(`AOC_A_DISP, 32'h0003_0102);
    cyc(40);
    `CHK(n_ret > 0, 1'b1)
    key_active <= 1'b1;
    cyc(2);
    k = n_ret;
    cyc(40);
    `CHK(n_ret, k)
    protect_key <= 1'b1;
    cyc(12);
    `CHK(n_prot, 0)
    cyc(30);
    `CHK(n_prot > 0, 1'b1)
    protect_key <= 1'b0;
    // manual start values
    auto_mv <= 16'sh007B;
    mreq();
    `CHK(manual_mv, 16'sh007B)
    wr(`AOC_A_MANV, 32'h0000_00C8);
    wr(`AOC_A_MODE, 32'h0000_002E);
    cyc(1);
    `CHK(id_unit_fine, 1'b1)
    mreq();
    `CHK(manual_mv, 16'sh00C8)
    wr(`AOC_A_MANV, 32'h0000_FC18);
    mreq();
    `CHK(manual_mv, `AOC_STD_LO)
    heat_cool <= 1'b1;
    wr(`AOC_A_MANV, 32'h0000_FC18);
    mreq();
    `CHK(manual_mv, 16'shFC18)
    wr(`AOC_A_MLIM, 32'h0064_0000);
    wr(`AOC_A_MODE, 32'h0000_003E);
    wr(`AOC_A_MANV, 32'h0000_01F4);
    mreq();
    `CHK(manual_mv, 16'sh0064)
    wr(`AOC_A_MODE, 32'h0000_0028);
    `CHK(cj_internal_on, 1'b0)
    `CHK(hs_alarm, 1'b0)
    print_verdict();
  end
endmodule : alarm_output_conditioning_bench
`default_nettype wire
